/* design/brake_sup_pkg.sv */
// package: constants and types of the brake supervisor
package brake_sup_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // parameter indices on the parameter port
  localparam logic [15:0] OFS_SYSTEM_RESET_SELECT = 16'h3000;
  localparam logic [15:0] OFS_REQUIRED_BRAKE_TIME = 16'h3006;
  localparam logic [15:0] OFS_PROGRAMMING_PASSWORD = 16'h3008;
  localparam logic [15:0] OFS_EXPERT_PASSWORD = 16'h3009;
  localparam logic [15:0] OFS_FIRST_BRAKE_FACTOR = 16'h4032;
  localparam logic [15:0] OFS_MAINS_LOSS_MONITOR_TIME = 16'h4501;
  localparam logic [15:0] OFS_MAINS_SWITCH_OFF_THRESHOLD = 16'h4507;
  localparam logic [15:0] OFS_STATUS = 16'h3f00;
  // reset values and ranges
  localparam logic [15:0] RST_SYSTEM_RESET_SELECT = 16'h0000;
  localparam logic [15:0] MAX_SYSTEM_RESET_SELECT = 16'h0004;
  localparam logic [15:0] RST_PROGRAMMING_PASSWORD = 16'h0002;
  localparam logic [15:0] RST_EXPERT_PASSWORD = 16'h00c3;
  localparam logic [15:0] MAX_PASSWORD = 16'h00c8;
  localparam logic [15:0] RST_MAINS_LOSS_MONITOR_TIME = 16'h00fa;
  localparam logic [15:0] MAX_MAINS_LOSS_MONITOR_TIME = 16'h2710;
  localparam logic [15:0] RST_MAINS_SWITCH_OFF_THRESHOLD = 16'h0014;
  localparam logic [15:0] MAX_MAINS_SWITCH_OFF_THRESHOLD = 16'h02bc;
  localparam logic [15:0] RST_REQUIRED_BRAKE_TIME = 16'h1f40; // 8000 ms
  localparam logic [15:0] RST_FIRST_BRAKE_FACTOR = 16'h0019;  // tenths, 2.5
  localparam logic [15:0] CURRENT_MIN_PCT = 16'h000f;
  localparam logic [15:0] CURRENT_MAX_PCT = 16'h0064;
  // reset selections
  localparam logic [15:0] SEL_NONE = 16'h0000;
  localparam logic [15:0] SEL_FACTORY = 16'h0001;
  localparam logic [15:0] SEL_CAN = 16'h0002;
  localparam logic [15:0] SEL_FAULTS = 16'h0003;
  localparam logic [15:0] SEL_MAXVAL = 16'h0004;
  // times and current step
  localparam int unsigned RESET_HOLD_MS = 15000;
  localparam int unsigned LONG_PRESS_MS = 1000;
  localparam int unsigned LED_PULSE_MS = 500;
  localparam logic [15:0] CURRENT_STEP_PCT = 16'h0001;

  typedef enum logic [2:0] {MENU_MAIN, MENU_FAULT, MENU_GROUP, MENU_MSGS} menu_t;
  typedef enum logic [1:0] {GRP_COMBINED, GRP_DEVICE, GRP_STATUS} group_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [15:0] wdata;
  } param_req_t;

  typedef struct packed {
    logic press;
    logic release_ev;
    logic enc_up;
    logic enc_down;
  } panel_t;
endpackage

/* design/brake_sup.sv */
// brake supervisor: mains loss, passwords, menus, resets, brake current
`timescale 1ns/10ps
// Operation
// - two mains phases compared with threshold 0..700 V, default 20.
// - below threshold for monitor time 0..10000 ms, default 250: combined fault.
// - programming mode only with first password 0..200, default 2.
// - expert mode only with second password 0..200, default 195.
// - reset selection accepts 0..4, default 0.
// - any fault outside programming mode shows fault mode with group and cause.
// - short press enters groups; encoder picks, press activates, encoder scrolls.
// - in a group short press returns to groups, long press to fault.
// - long press in fault mode goes to main menu.
// - reset input held 15 s restores defaults, pulses yellow indicator.
// - expert system reset confirmed with 1 restores defaults, pulses indicator.
// - parameter write of 1 to reset select restores defaults.
// - adaptive brake current kept within 15..100 percent of maximum.
// - first brake uses factor times rated current, clipped to maximum.
// - setpoint updated after each braking toward required time.
// - setpoint converges within three brakings after tool or time change.
// - required braking time parameter, factory value 8 s.
// - learned brake values handed out for non-volatile storage.
// - optimisation inactive until required time elapsed since motor start.
// - without standstill, notification stays open until safety time expires.
module brake_sup #(
  parameter int unsigned RESET_HOLD_CYC = brake_sup_pkg::RESET_HOLD_MS * brake_sup_pkg::CYC_PER_MS,
  parameter int unsigned LONG_PRESS_CYC = brake_sup_pkg::LONG_PRESS_MS * brake_sup_pkg::CYC_PER_MS,
  parameter int unsigned LED_PULSE_CYC = brake_sup_pkg::LED_PULSE_MS * brake_sup_pkg::CYC_PER_MS,
  parameter int unsigned MS_CYC = brake_sup_pkg::CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire brake_sup_pkg::param_req_t preq,
  output logic [15:0] prdata,
  output logic perr,
  input wire brake_sup_pkg::panel_t panel,
  input wire logic [15:0] entered_password,
  input wire logic password_submit,
  input wire logic expert_reset_confirm,
  input wire logic [15:0] mains_voltage_a,
  input wire logic [15:0] mains_voltage_b,
  input wire logic device_fault,
  input wire logic [7:0] fault_cause,
  input wire logic reset_input_terminal,
  input wire logic motor_start,
  input wire logic brake_done,
  input wire logic [15:0] measured_stop_ms,
  input wire logic standstill_seen,
  input wire logic safety_time_done,
  input wire logic [15:0] rated_motor_current,
  input wire logic [15:0] max_device_brake_current,
  input wire logic [15:0] stored_current_pct,
  input wire logic stored_valid,
  output logic [15:0] brake_current_set,
  output logic [15:0] learned_current_pct,
  output logic learned_store,
  output logic standstill_output_closed,
  output logic combined_fault,
  output logic yellow_led,
  output logic programming_mode,
  output logic expert_mode,
  output brake_sup_pkg::menu_t menu_state,
  output brake_sup_pkg::group_t menu_group,
  output logic [7:0] message_index,
  output logic [7:0] shown_cause,
  output logic can_reset_pulse,
  output logic fault_clear_pulse,
  output logic maxval_clear_pulse
);
  import brake_sup_pkg::*;

  typedef struct packed {
    logic [15:0] reset_sel;
    logic [15:0] pw1;
    logic [15:0] pw2;
    logic [15:0] mon_time;
    logic [15:0] threshold;
    logic [15:0] req_time;
    logic [15:0] factor;
    logic [31:0] ms_div;
    logic [15:0] low_ms;
    logic fault;
    logic [31:0] hold_cnt;
    logic [31:0] press_cnt;
    logic pressing;
    logic [31:0] led_cnt;
    logic prog;
    logic expert;
    menu_t menu;
    group_t group;
    logic [7:0] msg;
    logic [7:0] cause;
    logic [15:0] pct;
    logic first;
    logic [15:0] run_ms;
    logic opt_ok;
    logic store;
    logic ss_closed;
    logic can_p;
    logic flt_p;
    logic max_p;
    logic [15:0] rdata;
    logic rerr;
  } state_t;

  state_t st_reg;
  state_t st_next;

  function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] mx);
    clip = (v > mx) ? mx : v;
  endfunction

  function automatic logic [15:0] pct_to_amps(input logic [15:0] pct, input logic [15:0] imax);
    logic [31:0] p;
    p = 32'(pct) * 32'(imax);
    pct_to_amps = 16'(p / 32'(CURRENT_MAX_PCT));
  endfunction

  logic ms_tick;
  logic below;
  logic long_rel;
  logic short_rel;
  logic do_default;
  logic [31:0] first_amps;
  logic [15:0] first_pct;
  logic [31:0] step;

  always_comb
  begin
    ms_tick = (st_reg.ms_div == 32'(MS_CYC - 1));
    below = (mains_voltage_a < st_reg.threshold) || (mains_voltage_b < st_reg.threshold);
    long_rel = panel.release_ev && st_reg.pressing && (st_reg.press_cnt >= 32'(LONG_PRESS_CYC));
    short_rel = panel.release_ev && st_reg.pressing && (st_reg.press_cnt < 32'(LONG_PRESS_CYC));
    first_amps = 32'(rated_motor_current) * 32'(st_reg.factor) / 32'd10;
    if (max_device_brake_current == 16'h0000)
      first_pct = CURRENT_MAX_PCT;
    else
      first_pct = 16'(32'(clip(16'(first_amps), max_device_brake_current)) * 32'(CURRENT_MAX_PCT)
                  / 32'(max_device_brake_current));
    step = 32'(st_reg.pct) * 32'(measured_stop_ms) / 32'(st_reg.req_time | 16'h0001);
  end

  always_comb
  begin
    st_next = st_reg;
    do_default = 1'b0;
    st_next.store = 1'b0;
    st_next.can_p = 1'b0;
    st_next.flt_p = 1'b0;
    st_next.max_p = 1'b0;
    st_next.rerr = 1'b0;
    st_next.ms_div = ms_tick ? 32'd0 : st_reg.ms_div + 32'd1;

    // mains loss qualification counts whole milliseconds
    if (!below)
      st_next.low_ms = 16'h0000;
    else if (ms_tick && st_reg.low_ms < st_reg.mon_time)
      st_next.low_ms = st_reg.low_ms + 16'h0001;
    if (below && st_reg.low_ms >= st_reg.mon_time)
      st_next.fault = 1'b1;
    // fault is latched until a fault storage clear
    if (st_reg.flt_p && !(below && st_reg.low_ms >= st_reg.mon_time))
      st_next.fault = 1'b0;

    // bridge must hold throughout
    if (!reset_input_terminal)
      st_next.hold_cnt = 32'd0;
    else if (st_reg.hold_cnt < 32'(RESET_HOLD_CYC))
      st_next.hold_cnt = st_reg.hold_cnt + 32'd1;
    if (reset_input_terminal && st_reg.hold_cnt == 32'(RESET_HOLD_CYC - 1))
      do_default = 1'b1;

    // press duration, saturating so a stuck button cannot wrap
    if (panel.press)
    begin
      st_next.pressing = 1'b1;
      st_next.press_cnt = 32'd0;
    end
    else if (st_reg.pressing && st_reg.press_cnt < 32'(LONG_PRESS_CYC))
      st_next.press_cnt = st_reg.press_cnt + 32'd1;
    if (panel.release_ev)
      st_next.pressing = 1'b0;

    // passwords checked only on submission
    if (password_submit)
    begin
      if (entered_password == st_reg.pw1)
        st_next.prog = 1'b1;
      if (st_reg.prog && entered_password == st_reg.pw2)
        st_next.expert = 1'b1;
    end
    if (st_reg.expert && expert_reset_confirm)
      do_default = 1'b1;

    // display menu
    if ((st_reg.fault || device_fault) && st_reg.menu == MENU_MAIN && !(st_reg.prog))
    begin
      st_next.menu = MENU_FAULT;
      st_next.group = st_reg.fault ? GRP_COMBINED : GRP_DEVICE;
      st_next.cause = st_reg.fault ? 8'h01 : fault_cause;
    end
    unique case (st_reg.menu)
      MENU_MAIN: ;
      MENU_FAULT:
        if (long_rel)
          st_next.menu = MENU_MAIN;
        else if (short_rel)
          st_next.menu = MENU_GROUP;
      MENU_GROUP:
        if (long_rel)
          st_next.menu = MENU_FAULT;
        else if (short_rel)
        begin
          st_next.menu = MENU_MSGS;
          st_next.msg = 8'h00;
        end
        else if (panel.enc_up)
          st_next.group = (st_reg.group == GRP_STATUS) ? GRP_COMBINED : group_t'(st_reg.group + 2'd1);
        else if (panel.enc_down)
          st_next.group = (st_reg.group == GRP_COMBINED) ? GRP_STATUS : group_t'(st_reg.group - 2'd1);
      MENU_MSGS:
        if (long_rel)
          st_next.menu = MENU_FAULT;
        else if (short_rel)
          st_next.menu = MENU_GROUP;
        else if (panel.enc_up)
          st_next.msg = st_reg.msg + 8'h01;
        else if (panel.enc_down)
          st_next.msg = st_reg.msg - 8'h01;
      default: st_next.menu = MENU_MAIN;
    endcase

    // parameter port writes; out-of-range values are refused, not clipped
    if (preq.wr)
    begin
      unique case (preq.index)
        OFS_SYSTEM_RESET_SELECT:
          if (preq.wdata <= MAX_SYSTEM_RESET_SELECT)
          begin
            st_next.reset_sel = preq.wdata;
            if (preq.wdata == SEL_FACTORY)
              do_default = 1'b1;
            st_next.can_p = (preq.wdata == SEL_CAN);
            st_next.flt_p = (preq.wdata == SEL_FAULTS);
            st_next.max_p = (preq.wdata == SEL_MAXVAL);
          end
          else
            st_next.rerr = 1'b1;
        OFS_PROGRAMMING_PASSWORD:
          if (preq.wdata <= MAX_PASSWORD) st_next.pw1 = preq.wdata; else st_next.rerr = 1'b1;
        OFS_EXPERT_PASSWORD:
          if (preq.wdata <= MAX_PASSWORD) st_next.pw2 = preq.wdata; else st_next.rerr = 1'b1;
        OFS_MAINS_LOSS_MONITOR_TIME:
          if (preq.wdata <= MAX_MAINS_LOSS_MONITOR_TIME) st_next.mon_time = preq.wdata;
          else st_next.rerr = 1'b1;
        OFS_MAINS_SWITCH_OFF_THRESHOLD:
          if (preq.wdata <= MAX_MAINS_SWITCH_OFF_THRESHOLD) st_next.threshold = preq.wdata;
          else st_next.rerr = 1'b1;
        OFS_REQUIRED_BRAKE_TIME:
        begin
          st_next.req_time = preq.wdata;
          st_next.first = 1'b1;
        end
        OFS_FIRST_BRAKE_FACTOR: st_next.factor = preq.wdata;
        default: st_next.rerr = 1'b1;
      endcase
    end

    // parameter reads answer one cycle later
    if (preq.rd)
    begin
      unique case (preq.index)
        OFS_SYSTEM_RESET_SELECT: st_next.rdata = st_reg.reset_sel;
        OFS_PROGRAMMING_PASSWORD: st_next.rdata = st_reg.pw1;
        OFS_EXPERT_PASSWORD: st_next.rdata = st_reg.pw2;
        OFS_MAINS_LOSS_MONITOR_TIME: st_next.rdata = st_reg.mon_time;
        OFS_MAINS_SWITCH_OFF_THRESHOLD: st_next.rdata = st_reg.threshold;
        OFS_REQUIRED_BRAKE_TIME: st_next.rdata = st_reg.req_time;
        OFS_FIRST_BRAKE_FACTOR: st_next.rdata = st_reg.factor;
        OFS_STATUS: st_next.rdata = {11'h000, st_reg.ss_closed, st_reg.opt_ok, st_reg.expert,
                                     st_reg.prog, st_reg.fault};
        default:
        begin
          st_next.rdata = 16'h0000;
          st_next.rerr = 1'b1;
        end
      endcase
    end

    // run time since motor start gates optimisation
    if (motor_start)
    begin
      st_next.run_ms = 16'h0000;
      st_next.opt_ok = 1'b0;
      st_next.ss_closed = 1'b0;
    end
    else if (ms_tick && !st_reg.opt_ok)
    begin
      st_next.run_ms = st_reg.run_ms + 16'h0001;
      if (st_reg.run_ms + 16'h0001 >= st_reg.req_time)
        st_next.opt_ok = 1'b1;
    end

    // proportional update; stop time scales with 1/current
    if (brake_done && st_reg.opt_ok)
    begin
      if (st_reg.first)
        st_next.pct = clip(first_pct < CURRENT_MIN_PCT ? CURRENT_MIN_PCT : first_pct,
                           CURRENT_MAX_PCT);
      else if (step < 32'(CURRENT_MIN_PCT))
        st_next.pct = CURRENT_MIN_PCT;
      else if (step > 32'(CURRENT_MAX_PCT))
        st_next.pct = CURRENT_MAX_PCT;
      else
        st_next.pct = 16'(step);
      st_next.first = 1'b0;
      st_next.store = 1'b1;
    end

    // contact closes on standstill or safety time
    if (standstill_seen || safety_time_done)
      st_next.ss_closed = 1'b1;

    // factory defaults; learned current is kept but next brake starts fresh
    if (st_reg.led_cnt != 32'd0)
      st_next.led_cnt = st_reg.led_cnt - 32'd1;
    if (do_default)
    begin
      st_next.reset_sel = RST_SYSTEM_RESET_SELECT;
      st_next.pw1 = RST_PROGRAMMING_PASSWORD;
      st_next.pw2 = RST_EXPERT_PASSWORD;
      st_next.mon_time = RST_MAINS_LOSS_MONITOR_TIME;
      st_next.threshold = RST_MAINS_SWITCH_OFF_THRESHOLD;
      st_next.req_time = RST_REQUIRED_BRAKE_TIME;
      st_next.factor = RST_FIRST_BRAKE_FACTOR;
      st_next.first = 1'b1;
      st_next.prog = 1'b0;
      st_next.expert = 1'b0;
      st_next.led_cnt = 32'(LED_PULSE_CYC);
    end
  end

  // learned value reloaded from storage once after reset
  logic loaded_reg;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.reset_sel <= RST_SYSTEM_RESET_SELECT;
      st_reg.pw1 <= RST_PROGRAMMING_PASSWORD;
      st_reg.pw2 <= RST_EXPERT_PASSWORD;
      st_reg.mon_time <= RST_MAINS_LOSS_MONITOR_TIME;
      st_reg.threshold <= RST_MAINS_SWITCH_OFF_THRESHOLD;
      st_reg.req_time <= RST_REQUIRED_BRAKE_TIME;
      st_reg.factor <= RST_FIRST_BRAKE_FACTOR;
      st_reg.pct <= CURRENT_MAX_PCT;
      st_reg.first <= 1'b1;
      st_reg.menu <= MENU_MAIN;
      st_reg.group <= GRP_COMBINED;
      loaded_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      loaded_reg <= 1'b1;
      if (!loaded_reg && stored_valid)
      begin
        st_reg.pct <= clip(stored_current_pct < CURRENT_MIN_PCT ? CURRENT_MIN_PCT
                           : stored_current_pct, CURRENT_MAX_PCT);
        st_reg.first <= 1'b0;
      end
    end
  end

  assign prdata = st_reg.rdata;
  assign perr = st_reg.rerr;
  assign brake_current_set = pct_to_amps(st_reg.pct, max_device_brake_current);
  assign learned_current_pct = st_reg.pct;
  assign learned_store = st_reg.store;
  assign standstill_output_closed = st_reg.ss_closed;
  assign combined_fault = st_reg.fault;
  assign yellow_led = (st_reg.led_cnt != 32'd0);
  assign programming_mode = st_reg.prog;
  assign expert_mode = st_reg.expert;
  assign menu_state = st_reg.menu;
  assign menu_group = st_reg.group;
  assign message_index = st_reg.msg;
  assign shown_cause = st_reg.cause;
  assign can_reset_pulse = st_reg.can_p;
  assign fault_clear_pulse = st_reg.flt_p;
  assign maxval_clear_pulse = st_reg.max_p;
endmodule

/* test/brake_sup_monitor.sv */
// checker: properties of the brake supervisor
`timescale 1ns/10ps
module brake_sup_monitor
  import brake_sup_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire brake_sup_pkg::param_req_t preq,
  input wire logic perr,
  input wire brake_sup_pkg::panel_t panel,
  input wire logic password_submit,
  input wire logic [15:0] learned_current_pct,
  input wire logic learned_store,
  input wire logic yellow_led,
  input wire logic programming_mode,
  input wire logic expert_mode,
  input wire brake_sup_pkg::menu_t menu_state,
  input wire logic can_reset_pulse,
  input wire logic fault_clear_pulse,
  input wire logic maxval_clear_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // write of a selection value
  sequence sel_wr(logic [15:0] v);
    preq.wr && preq.index == OFS_SYSTEM_RESET_SELECT && preq.wdata == v;
  endsequence
  // fault mode just left
  sequence left_fault;
    menu_state == MENU_MAIN && $past(menu_state) == MENU_FAULT;
  endsequence
  can_pulse_a: assert property (sel_wr(SEL_CAN) |=> can_reset_pulse)
    else $error("no link reset pulse");
  fault_pulse_a: assert property (sel_wr(SEL_FAULTS) |=> fault_clear_pulse)
    else $error("no fault clear pulse");
  maxval_cause_a: assert property (maxval_clear_pulse |->
    $past(preq.wr && preq.index == OFS_SYSTEM_RESET_SELECT && preq.wdata == SEL_MAXVAL))
    else $error("stray max value clear");
  led_pulse_a: assert property (sel_wr(SEL_FACTORY) |=> yellow_led [*8])
    else $error("indicator not lit");
  perr_cause_a: assert property (perr |-> $past(preq.wr || preq.rd))
    else $error("stray refusal");
  prog_entry_a: assert property ($rose(programming_mode) |-> $past(password_submit))
    else $error("programming without password");
  expert_entry_a: assert property ($rose(expert_mode) |->
    $past(programming_mode && password_submit))
    else $error("expert outside programming");
  fault_exit_a: assert property (left_fault |-> $past(panel.release_ev))
    else $error("fault left without release");
  pct_range_a: assert property (learned_store |->
    learned_current_pct inside {[CURRENT_MIN_PCT:CURRENT_MAX_PCT]})
    else $error("learned current outside its range");
endmodule

bind brake_sup brake_sup_monitor i_brake_sup_monitor (.mclk(mclk), .rst_n(rst_n), .preq(preq),
  .perr(perr), .panel(panel), .password_submit(password_submit),
  .learned_current_pct(learned_current_pct), .learned_store(learned_store),
  .yellow_led(yellow_led), .programming_mode(programming_mode), .expert_mode(expert_mode),
  .menu_state(menu_state), .can_reset_pulse(can_reset_pulse),
  .fault_clear_pulse(fault_clear_pulse), .maxval_clear_pulse(maxval_clear_pulse));

/* test/brake_sup_partner.sv */
// partner model: parameter master and operator panel
`timescale 1ns/10ps
module brake_sup_partner
  import brake_sup_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] prdata,
  input wire logic perr,
  output brake_sup_pkg::param_req_t preq,
  output brake_sup_pkg::panel_t panel
);
  initial
  begin
    preq = '0;
    panel = '0;
  end
  // one word per access, answer taken at the next edge
  task automatic access(input logic w, input logic [15:0] idx, input logic [15:0] wd,
                        output logic [15:0] rd, output logic err);
    @(posedge mclk);
    preq <= '{w, !w, idx, wd};
    @(posedge mclk);
    preq <= '0;
    #1;
    rd = prdata;
    err = perr;
  endtask
  // press, hold, release
  task automatic push(input int hold);
    @(posedge mclk);
    panel.press <= 1'b1;
    @(posedge mclk);
    panel.press <= 1'b0;
    repeat (hold) @(posedge mclk);
    panel.release_ev <= 1'b1;
    @(posedge mclk);
    panel.release_ev <= 1'b0;
    #1;
  endtask
  // one encoder detent upward
  task automatic turn;
    @(posedge mclk);
    panel.enc_up <= 1'b1;
    @(posedge mclk);
    panel.enc_up <= 1'b0;
    #1;
  endtask
endmodule

/* test/brake_sup_tb.sv */
// testbench for the brake supervisor
`timescale 1ns/10ps
module brake_sup_tb;
  import brake_sup_pkg::*;
  localparam int LONGC = 20;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  param_req_t preq;
  panel_t panel;
  menu_t menu;
  group_t grp;
  logic [15:0] prdata, v, pw, entered, ua, ub, rated, bmax, pct, stop, bset, lpct;
  logic perr, err, submit, confirm, term, mstart, bdone, std;
  logic lstore, ssout, cfault, led, prog, expert, canp, fltp, maxp;
  logic [7:0] cause, msg, shown;
  logic [2:0] pulses = 3'h0;
  logic [15:0] regs [6] = '{OFS_MAINS_SWITCH_OFF_THRESHOLD, OFS_MAINS_LOSS_MONITOR_TIME,
    OFS_PROGRAMMING_PASSWORD, OFS_EXPERT_PASSWORD, OFS_SYSTEM_RESET_SELECT,
    OFS_REQUIRED_BRAKE_TIME};
  logic [15:0] rsts [6] = '{RST_MAINS_SWITCH_OFF_THRESHOLD, RST_MAINS_LOSS_MONITOR_TIME,
    RST_PROGRAMMING_PASSWORD, RST_EXPERT_PASSWORD, RST_SYSTEM_RESET_SELECT,
    RST_REQUIRED_BRAKE_TIME};
  logic [15:0] sels [3] = '{SEL_CAN, SEL_FAULTS, SEL_MAXVAL};
  int fail_count = 0;
  int checked = 0;
  int seed = 32'hcfe278e9;

  always #10 mclk = ~mclk;
  // one-cycle pulses latched off the launching edge
  always @(negedge mclk) pulses <= pulses | {maxp, fltp, canp};

  brake_sup #(.RESET_HOLD_CYC(100), .LONG_PRESS_CYC(LONGC), .LED_PULSE_CYC(10), .MS_CYC(5))
  i_brake_sup (.mclk(mclk), .rst_n(rst_n), .preq(preq), .prdata(prdata), .perr(perr),
    .panel(panel), .entered_password(entered), .password_submit(submit),
    .expert_reset_confirm(confirm), .mains_voltage_a(ua), .mains_voltage_b(ub),
    .device_fault(1'b0), .fault_cause(cause), .reset_input_terminal(term),
    .motor_start(mstart), .brake_done(bdone), .measured_stop_ms(stop),
    .standstill_seen(1'b0), .safety_time_done(std), .rated_motor_current(rated),
    .max_device_brake_current(bmax), .stored_current_pct(16'h0000), .stored_valid(1'b0),
    .brake_current_set(bset), .learned_current_pct(lpct), .learned_store(lstore),
    .standstill_output_closed(ssout), .combined_fault(cfault), .yellow_led(led),
    .programming_mode(prog), .expert_mode(expert), .menu_state(menu), .menu_group(grp),
    .message_index(msg), .shown_cause(shown), .can_reset_pulse(canp),
    .fault_clear_pulse(fltp), .maxval_clear_pulse(maxp));
  brake_sup_partner i_brake_sup_partner (.mclk(mclk), .prdata(prdata), .perr(perr),
    .preq(preq), .panel(panel));

  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    checked++;
    if (got !== want)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] idx, input logic [15:0] wd, input logic e);
    i_brake_sup_partner.access(w, idx, wd, v, err);
    check(16'(err), 16'(e), "refusal flag");
  endtask
  task automatic get(input logic [15:0] idx, input logic [15:0] want);
    acc(1'b0, idx, 16'h0000, 1'b0);
    check(v, want, "read back");
  endtask
  task automatic cm(input menu_t want);
    check(16'(menu), 16'(want), "menu state");
  endtask
  task automatic sub(input logic [15:0] p);
    @(posedge mclk);
    entered <= p;
    submit <= 1'b1;
    @(posedge mclk);
    submit <= 1'b0;
    #1;
  endtask
  // motor start, run, one braking
  task automatic brake(input logic [15:0] s, input int run);
    @(posedge mclk);
    mstart <= 1'b1;
    @(posedge mclk);
    mstart <= 1'b0;
    repeat (run) @(posedge mclk);
    stop <= s;
    bdone <= 1'b1;
    @(posedge mclk);
    bdone <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  function automatic logic [15:0] clip(input logic [31:0] p);
    clip = p < 32'hf ? 16'h000f : (p > 32'h64 ? 16'h0064 : p[15:0]);
  endfunction
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang limit
  initial
  begin
    #(20 * 20000);
    fail_count++;
    end_of_test;
  end

  initial
  begin
    {entered, submit, confirm, term, mstart, bdone, stop, std} = '0;
    ua = 16'h00dc;
    ub = 16'h00dc;
    bmax = 16'h00c8;
    cause = 8'($random(seed));
    rated = (16'($random(seed)) & 16'h003c) + 16'h0004; // exact math
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (regs[i]) get(regs[i], rsts[i]);
    acc(1'b0, 16'h1234, 16'h0000, 1'b1);
    acc(1'b1, OFS_MAINS_SWITCH_OFF_THRESHOLD, 16'h02bd, 1'b1);
    acc(1'b1, OFS_MAINS_SWITCH_OFF_THRESHOLD, 16'h02bc, 1'b0);
    acc(1'b1, OFS_MAINS_LOSS_MONITOR_TIME, 16'h2711, 1'b1);
    acc(1'b1, OFS_PROGRAMMING_PASSWORD, 16'h00c9, 1'b1);
    acc(1'b1, OFS_SYSTEM_RESET_SELECT, 16'h0005, 1'b1);
    pw = 16'($unsigned($random(seed)) % 201);
    acc(1'b1, OFS_PROGRAMMING_PASSWORD, pw, 1'b0);
    get(OFS_PROGRAMMING_PASSWORD, pw);
    done("register map");
    // mains loss on one phase for a 2 ms monitor time
    acc(1'b1, OFS_MAINS_SWITCH_OFF_THRESHOLD, 16'h0064, 1'b0);
    acc(1'b1, OFS_MAINS_LOSS_MONITOR_TIME, 16'h0002, 1'b0);
    ua <= 16'h0032;
    repeat (5) @(posedge mclk);
    #1 check(16'(cfault), 16'h0000, "early fault");
    repeat (20) @(posedge mclk);
    #1 check(16'(cfault), 16'h0001, "mains fault");
    cm(MENU_FAULT);
    check({8'h00, shown}, 16'h0001, "fault cause");
    ua <= 16'h00dc;
    acc(1'b1, OFS_SYSTEM_RESET_SELECT, SEL_FAULTS, 1'b0);
    repeat (2) @(posedge mclk);
    #1 check(16'(cfault), 16'h0000, "fault cleared");
    done("mains loss");
    i_brake_sup_partner.push(3);
    cm(MENU_GROUP);
    i_brake_sup_partner.turn;
    check({14'h0000, grp}, {14'h0000, GRP_DEVICE}, "group");
    i_brake_sup_partner.push(LONGC - 6);
    cm(MENU_MSGS);
    i_brake_sup_partner.turn;
    check({8'h00, msg}, 16'h0001, "message");
    i_brake_sup_partner.push(3);
    cm(MENU_GROUP);
    i_brake_sup_partner.push(3);
    i_brake_sup_partner.push(LONGC);
    cm(MENU_FAULT);
    i_brake_sup_partner.push(LONGC);
    cm(MENU_MAIN);
    done("fault menu");
    sub(pw ^ 16'h0001);
    check(16'(prog), 16'h0000, "wrong password");
    sub(pw);
    check(16'(prog), 16'h0001, "programming");
    sub(RST_EXPERT_PASSWORD);
    check(16'(expert), 16'h0001, "expert");
    @(posedge mclk);
    confirm <= 1'b1;
    @(posedge mclk);
    confirm <= 1'b0;
    @(posedge mclk);
    #1 check({15'h0000, led}, 16'h0001, "indicator");
    get(OFS_PROGRAMMING_PASSWORD, RST_PROGRAMMING_PASSWORD);
    done("passwords");
    foreach (sels[i])
    begin
      acc(1'b1, OFS_SYSTEM_RESET_SELECT, sels[i], 1'b0);
      get(OFS_SYSTEM_RESET_SELECT, sels[i]);
    end
    check({13'h0000, pulses}, 16'h0007, "selection pulses");
    acc(1'b1, OFS_PROGRAMMING_PASSWORD, 16'h0009, 1'b0);
    acc(1'b1, OFS_SYSTEM_RESET_SELECT, SEL_FACTORY, 1'b0);
    @(posedge mclk);
    #1 check({15'h0000, led}, 16'h0001, "indicator");
    get(OFS_PROGRAMMING_PASSWORD, RST_PROGRAMMING_PASSWORD);
    get(OFS_SYSTEM_RESET_SELECT, RST_SYSTEM_RESET_SELECT);
    done("parameter reset");
    acc(1'b1, OFS_PROGRAMMING_PASSWORD, 16'h0009, 1'b0);
    term <= 1'b1;
    repeat (60) @(posedge mclk);
    term <= 1'b0;
    @(posedge mclk);
    term <= 1'b1;
    repeat (60) @(posedge mclk);
    term <= 1'b0;
    get(OFS_PROGRAMMING_PASSWORD, 16'h0009);
    term <= 1'b1;
    repeat (104) @(posedge mclk);
    #1 check({15'h0000, led}, 16'h0001, "indicator");
    term <= 1'b0;
    get(OFS_PROGRAMMING_PASSWORD, RST_PROGRAMMING_PASSWORD);
    done("reset terminal");
    acc(1'b1, OFS_REQUIRED_BRAKE_TIME, 16'h0004, 1'b0);
    brake(16'h0010, 2);
    check(lpct, 16'h0064, "early brake");
    pct = clip(32'(RST_FIRST_BRAKE_FACTOR) * rated * 32'ha / bmax);
    brake(16'h0004, 30);
    check(lpct, pct, "first brake");
    check(bset, pct * bmax / 16'h0064, "brake current");
    v = ((16'($random(seed)) & 16'h0003) + 16'h0001) << 2;
    brake(v, 30);
    check(lpct, clip(pct * v / 16'h0004), "adapted brake");
    check(16'(ssout), 16'h0000, "contact open");
    std <= 1'b1;
    @(posedge mclk);
    std <= 1'b0;
    #1 check(16'(ssout), 16'h0001, "contact closed");
    done("brake current");
    end_of_test;
  end
endmodule
